// file: design/pdm_port.sv
// pin drive mode port: apb registers, drive decode, pin input and
// edge interrupts for one port of pins
// assumes pins arrive asynchronously and pad cells obey the controls
//
// Functional notes
// R1: each pin has its own three-bit drive select field, eight behaviours.
// R2: driver acts on output value, or routed peripheral signal under bypass.
// R3: code 000 is reset default; driver and input buffer both off.
// R4: code 001 keeps output floating, input buffer enabled.
// R5: 010 resistive high/strong low; 011 strong high/resistive low.
// R6: 100 strong low or float; 101 strong high or float.
// R7: 110 drives strongly high and low following data.
// R8: 111 resistive high for 1, resistive low for 0.
// R9: regulated special-function pins refuse the three resistive modes.
// R10: resistive and open-drain modes still read as digital inputs.
// R11: software should not read pins set to strong drive as inputs.
// R12: separate pin state and output value registers.
// R13: settings reachable per port (bit per pin) and per pin.
// R14: reset port state is programmable; drive modes applied at reset; pads here stay off until the first pclk edge after it.
// R15: each pin may interrupt on rising, falling or both edges.
// R16: pin interrupts are edge-triggered only.
// R17: the port raises its own dedicated interrupt line.
// R18: usb-capable pins offer only cmos output drive.
// R19: each event sets its status bit and asserts the port request.
// R20: interrupt type is none, rising, falling or both.
// R21: routed output enable flips pin between digital hiz and its mode.
// R22: pin inputs pass a two-flop synchroniser before use.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pdm_port #(
	parameter int                 N        = pdm_pkg::NPIN,
	parameter logic [3*N-1:0]     RESET_DM = pdm_pkg::RST_DM,
	parameter logic [N-1:0]       RESET_OUT = pdm_pkg::RST_OUT,
	parameter logic [N-1:0]       SFP_MASK = pdm_pkg::NO_PINS,
	parameter logic [N-1:0]       USB_MASK = pdm_pkg::NO_PINS
) (
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [pdm_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [pdm_pkg::DATA_W-1:0]  pwdata,
	output logic      [pdm_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	// routed peripheral signals
	input  wire logic [N-1:0]                periph_out,
	input  wire logic [N-1:0]                periph_oe,
	// pins
	input  wire logic [N-1:0]                pin_in,
	output logic      [N-1:0]                pad_out,
	output logic      [N-1:0]                pad_oe,
	output logic      [N-1:0]                pad_pu_en,
	output logic      [N-1:0]                pad_pd_en,
	output logic      [N-1:0]                pad_ibuf_en,
	// interrupt
	output logic                             port_irq
);
	import pdm_pkg::*;

	logic [CFG_W-1:0]  cfg_ff [N];
	logic [N-1:0]      plane [CFG_W];
	logic [N-1:0]      sync1_ff;
	logic [N-1:0]      sync2_ff;
	logic [N-1:0]      sync3_ff;
	logic [N-1:0]      pin_state_reg_ff;
	logic [N-1:0]      int_stat_ff;
	logic [N-1:0]      nxt_int_stat;
	logic [N-1:0]      ev;
	logic [N-1:0]      ibuf_vec;
	logic [N-1:0]      clr;
	logic              pready_ff;
	logic              pslverr_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic [DATA_W-1:0] nxt_prdata;
	logic              nxt_err;
	logic              wr;
	logic              plane_hit;
	logic [3:0]        plane_pos;
	logic              cfg_hit;
	logic [2:0]        cfg_idx;
	logic              port_irq_ff;

	////////////////////////////////////////////////////////////////////
	// address decode

	assign wr      = psel && penable && pready_ff && pwrite;
	assign cfg_hit = (paddr[7:6] == PIN_CFG_PAGE) && (paddr[5] == 1'b0)
		&& (32'(paddr[4:2]) < N);
	assign cfg_idx = paddr[4:2];

	always_comb begin
		plane_hit = 1'b1;
		plane_pos = 4'(F_OUT);
		case (paddr)
			OFS_OUT:   plane_pos = 4'(F_OUT);
			OFS_DM0:   plane_pos = 4'(F_DM);
			OFS_DM1:   plane_pos = 4'(F_DM + 1);
			OFS_DM2:   plane_pos = 4'(F_DM + 2);
			OFS_BYP:   plane_pos = 4'(F_BYP);
			OFS_BIDIR: plane_pos = 4'(F_BIDIR);
			OFS_REGUL: plane_pos = 4'(F_REG);
			OFS_IT0:   plane_pos = 4'(F_IT);
			OFS_IT1:   plane_pos = 4'(F_IT + 1);
			default:   plane_hit = 1'b0;
		endcase
	end

	always_comb begin
		nxt_prdata = '0;
		nxt_err    = 1'b0;
		if (plane_hit) begin
			nxt_prdata[N-1:0] = plane[plane_pos]; // see R13
		end else if (paddr == OFS_STATE) begin
			nxt_prdata[N-1:0] = pin_state_reg_ff; // see R12
		end else if (paddr == OFS_STAT) begin
			nxt_prdata[N-1:0] = int_stat_ff;
		end else if (cfg_hit) begin
			nxt_prdata[CFG_W-1:0] = cfg_ff[cfg_idx]; // see R13
			nxt_prdata[F_STATE]   = pin_state_reg_ff[cfg_idx];
			nxt_prdata[F_STAT]    = int_stat_ff[cfg_idx];
		end else begin
			nxt_err = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb answer: one wait state, write commits with pready

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end else begin
			pready_ff  <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff && nxt_err;
			if (psel && penable && !pready_ff && !pwrite) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata  = prdata_ff;

	////////////////////////////////////////////////////////////////////
	// per-pin configuration, effective mode and output stage

	genvar p, b;
	generate
		for (p = 0; p < N; p++) begin : g_pin
			pdm_pin_if  pif ();
			pdm_mode_t  sel;
			pdm_mode_t  eff;
			logic       rise;
			logic       fall;

			for (b = 0; b < CFG_W; b++) begin : g_plane
				assign plane[b][p] = cfg_ff[p][b];
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_ff[p]                <= '0; // see R14
					cfg_ff[p][F_DM +: 3]     <= RESET_DM[3*p +: 3]; // see R3 R14
					cfg_ff[p][F_OUT]         <= RESET_OUT[p];
				end else if (wr && plane_hit) begin
					cfg_ff[p][plane_pos]     <= pwdata[p]; // see R13
				end else if (wr && cfg_hit && cfg_idx == 3'(p)) begin
					cfg_ff[p]                <= pwdata[CFG_W-1:0]; // see R1
				end
			end

			assign sel = pdm_mode_t'(cfg_ff[p][F_DM +: 3]); // see R1

			always_comb begin
				eff = sel;
				if (cfg_ff[p][F_BIDIR] && !periph_oe[p]) begin
					eff = DM_HIZ_DIGITAL; // see R21
				end else if (USB_MASK[p] && sel != DM_HIZ_ANALOG
					&& sel != DM_HIZ_DIGITAL) begin
					eff = DM_STRONG; // see R18
				end else if (SFP_MASK[p] && cfg_ff[p][F_REG]
					&& (sel == DM_RES_UP || sel == DM_RES_DOWN
					|| sel == DM_RES_BOTH)) begin
					eff = DM_HIZ_DIGITAL; // see R9
				end
			end

			assign pif.mode = eff;
			assign pif.data = cfg_ff[p][F_BYP] ? periph_out[p]
				: cfg_ff[p][F_OUT]; // see R2

			pdm_pin_drive u_drv (
				.pclk    (pclk),
				.presetn (presetn),
				.pin     (pif.drv)
			);

			assign pad_out[p]     = pif.pad_out;
			assign pad_oe[p]      = pif.pad_oe;
			assign pad_pu_en[p]   = pif.pad_pu;
			assign pad_pd_en[p]   = pif.pad_pd;
			assign pad_ibuf_en[p] = pif.pad_ibuf;
			assign ibuf_vec[p]    = (eff != DM_HIZ_ANALOG); // see R10

			assign rise = sync2_ff[p] && !sync3_ff[p];
			assign fall = !sync2_ff[p] && sync3_ff[p];

			always_comb begin
				case (pdm_int_t'(cfg_ff[p][F_IT +: 2])) // see R20
					INT_RISE: ev[p] = rise && ibuf_vec[p]; // see R15
					INT_FALL: ev[p] = fall && ibuf_vec[p];
					INT_BOTH: ev[p] = (rise || fall) && ibuf_vec[p];
					default:  ev[p] = 1'b0;
				endcase
			end

			assign clr[p] = wr && ((paddr == OFS_STAT && pwdata[p])
				|| (cfg_hit && cfg_idx == 3'(p) && pwdata[F_STAT]));
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// pin input synchroniser and pin state

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else begin
			sync1_ff <= pin_in; // see R22
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_state_reg_ff <= '0;
		end else begin
			pin_state_reg_ff <= sync2_ff & ibuf_vec; // see R3 R12
		end
	end

	////////////////////////////////////////////////////////////////////
	// edge interrupts: set wins over clear

	assign nxt_int_stat = ev | (int_stat_ff & ~clr); // see R16 R19

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_ff <= '0;
			port_irq_ff <= 1'b0;
		end else begin
			int_stat_ff <= nxt_int_stat;
			port_irq_ff <= |nxt_int_stat; // see R17
		end
	end

	assign port_irq = port_irq_ff;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_event;
		|ev;
	endsequence

	a_event_irq: assert property (s_event |=> port_irq // see R19 R17
		&& (int_stat_ff & $past(ev)) == $past(ev))
		else $error("pin event did not raise request");
	a_edge_only: assert property ((sync2_ff == sync3_ff) |=> // see R16
		(int_stat_ff & ~$past(int_stat_ff)) == '0)
		else $error("status set without an edge");
	a_sync_path: assert property (ibuf_vec == '1 [*2] |-> // see R22
		##1 pin_state_reg_ff == $past(pin_in, 3))
		else $error("pin state not three cycles behind pin");
	a_out_write: assert property (wr && paddr == OFS_OUT |=> // see R12
		plane[F_OUT] == $past(pwdata[N-1:0]))
		else $error("output value write lost");
	a_irq_level: assert property (port_irq == $past(|nxt_int_stat)) // see R17
		else $error("request not tied to status");

endmodule // pdm_port
`default_nettype wire

// file: design/pdm_pkg.sv
// constants and types shared by the pin drive mode port
// assumes a 32-bit apb slave with an 8-bit byte address
package pdm_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NPIN   = 8;

	// port-form registers, one bit per pin
	localparam logic [7:0] OFS_OUT    = 8'h00;
	localparam logic [7:0] OFS_STATE  = 8'h04;
	localparam logic [7:0] OFS_DM0    = 8'h08;
	localparam logic [7:0] OFS_DM1    = 8'h0C;
	localparam logic [7:0] OFS_DM2    = 8'h10;
	localparam logic [7:0] OFS_BYP    = 8'h14;
	localparam logic [7:0] OFS_BIDIR  = 8'h18;
	localparam logic [7:0] OFS_REGUL  = 8'h1C;
	localparam logic [7:0] OFS_IT0    = 8'h20;
	localparam logic [7:0] OFS_IT1    = 8'h24;
	localparam logic [7:0] OFS_STAT   = 8'h28;
	// pin-form registers: base plus four per pin
	localparam logic [1:0] PIN_CFG_PAGE = 2'h1;

	// field positions in a pin configuration word
	localparam int F_OUT   = 0;
	localparam int F_DM    = 1;
	localparam int F_BYP   = 4;
	localparam int F_BIDIR = 5;
	localparam int F_IT    = 6;
	localparam int F_REG   = 8;
	localparam int CFG_W   = 9;
	localparam int F_STATE = 9;
	localparam int F_STAT  = 10;

	// reset values of the port state
	localparam logic [3*NPIN-1:0] RST_DM  = 24'h00_0000;
	localparam logic [NPIN-1:0]   RST_OUT = 8'h00;
	localparam logic [NPIN-1:0]   NO_PINS = 8'h00;

	typedef enum logic [2:0] {
		DM_HIZ_ANALOG,
		DM_HIZ_DIGITAL,
		DM_RES_UP,
		DM_RES_DOWN,
		DM_OD_LOW,
		DM_OD_HIGH,
		DM_STRONG,
		DM_RES_BOTH
	} pdm_mode_t;

	typedef enum logic [1:0] {
		INT_NONE,
		INT_RISE,
		INT_FALL,
		INT_BOTH
	} pdm_int_t;

endpackage

// file: design/pdm_pin_if.sv
// per-pin carrier between port logic and one output stage decoder
// assumes both ends run on pclk
`timescale 1ns/10ps
`default_nettype none
interface pdm_pin_if;
	import pdm_pkg::*;
	pdm_mode_t mode;
	logic      data;
	logic      pad_out;
	logic      pad_oe;
	logic      pad_pu;
	logic      pad_pd;
	logic      pad_ibuf;

	modport port (output mode, data,
		input pad_out, pad_oe, pad_pu, pad_pd, pad_ibuf);
	modport drv (input mode, data,
		output pad_out, pad_oe, pad_pu, pad_pd, pad_ibuf);
endinterface
`default_nettype wire

// file: design/pdm_pin_drive.sv
// output stage decoder for one pin: mode and data to pad controls
// assumes an effective mode already resolved by the port logic
`timescale 1ns/10ps
`default_nettype none
module pdm_pin_drive (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// pin controls
	pdm_pin_if.drv    pin
);
	import pdm_pkg::*;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin.pad_out  <= 1'b0;
			pin.pad_oe   <= 1'b0;
			pin.pad_pu   <= 1'b0;
			pin.pad_pd   <= 1'b0;
			pin.pad_ibuf <= 1'b0;
		end else begin
			pin.pad_out  <= pin.data;
			pin.pad_ibuf <= (pin.mode != DM_HIZ_ANALOG); // see R3 R4 R10
			case (pin.mode)
				DM_RES_UP: begin // see R5
					pin.pad_oe <= !pin.data;
					pin.pad_pu <= pin.data;
					pin.pad_pd <= 1'b0;
				end
				DM_RES_DOWN: begin // see R5
					pin.pad_oe <= pin.data;
					pin.pad_pu <= 1'b0;
					pin.pad_pd <= !pin.data;
				end
				DM_OD_LOW: begin // see R6
					pin.pad_oe <= !pin.data;
					pin.pad_pu <= 1'b0;
					pin.pad_pd <= 1'b0;
				end
				DM_OD_HIGH: begin // see R6
					pin.pad_oe <= pin.data;
					pin.pad_pu <= 1'b0;
					pin.pad_pd <= 1'b0;
				end
				DM_STRONG: begin // see R7
					pin.pad_oe <= 1'b1;
					pin.pad_pu <= 1'b0;
					pin.pad_pd <= 1'b0;
				end
				DM_RES_BOTH: begin // see R8
					pin.pad_oe <= 1'b0;
					pin.pad_pu <= pin.data;
					pin.pad_pd <= !pin.data;
				end
				default: begin // see R3 R4
					pin.pad_oe <= 1'b0;
					pin.pad_pu <= 1'b0;
					pin.pad_pd <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_hiz_analog: assert property (pin.mode == DM_HIZ_ANALOG |=> // see R3
		!pin.pad_oe && !pin.pad_pu && !pin.pad_pd && !pin.pad_ibuf)
		else $error("analog mode drives or buffers");
	a_hiz_digital: assert property (pin.mode == DM_HIZ_DIGITAL |=> // see R4
		!pin.pad_oe && !pin.pad_pu && !pin.pad_pd && pin.pad_ibuf)
		else $error("digital hiz mode wrong");
	a_res_up: assert property (pin.mode == DM_RES_UP |=> // see R5
		pin.pad_oe == !$past(pin.data) && pin.pad_pu == $past(pin.data))
		else $error("resistive pull-up wrong");
	a_open_low: assert property (pin.mode == DM_OD_LOW |=> // see R6
		pin.pad_oe == !$past(pin.data) && !pin.pad_out == pin.pad_oe)
		else $error("open drain low wrong");
	a_strong_follow: assert property (pin.mode == DM_STRONG |=> // see R7
		pin.pad_oe && pin.pad_out == $past(pin.data))
		else $error("strong drive does not follow data");
	a_res_both: assert property (pin.mode == DM_RES_BOTH |=> // see R8
		!pin.pad_oe && pin.pad_pu == $past(pin.data)
		&& pin.pad_pd == !$past(pin.data))
		else $error("resistive both wrong");

endmodule // pdm_pin_drive
`default_nettype wire

// file: tb/pdm_pin_model.sv
// external circuit on each pin: a bench-driven source plus the pad
// assumes pad controls from pdm_port, all in the pclk domain
`timescale 1ns/10ps
`default_nettype none
module pdm_pin_model #(
	parameter int N = 8
) (
	// clock
	input  wire logic         pclk,
	// pad controls
	input  wire logic [N-1:0] pad_out,
	input  wire logic [N-1:0] pad_oe,
	input  wire logic [N-1:0] pad_pu_en,
	input  wire logic [N-1:0] pad_pd_en,
	// external source
	input  wire logic [N-1:0] ext_en,
	input  wire logic [N-1:0] ext_val,
	// pin level
	output logic      [N-1:0] pin_in
);
	logic [N-1:0] last_ff;

	always_ff @(posedge pclk) begin
		last_ff <= pin_in;
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (pad_oe[i])
				pin_in[i] = pad_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pad_pu_en[i] | pad_pd_en[i])
				pin_in[i] = pad_pu_en[i];
			else
				pin_in[i] = ~last_ff[i];
		end
	end
endmodule // pdm_pin_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for pdm_port: apb tasks drive the registers
// assumes pdm_pin_model closes the loop from the pads to pin_in
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pdm_pkg::*;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready, pslverr, port_irq;
	logic [7:0]  periph_out = '0;
	logic [7:0]  periph_oe = '0;
	logic [7:0]  pin_in, pad_out, pad_oe, pad_pu_en, pad_pd_en;
	logic [7:0]  pad_ibuf_en;
	logic [7:0]  ext_en = '1;
	logic [7:0]  ext_val = '0;
	logic [7:0]  dv, byp, bid, rg;
	logic [2:0]  code [8];
	logic [31:0] rd;
	logic        er;
	int          mismatches = 0;
	int          checked = 0;

	always #2 pclk = ~pclk;

	pdm_port #(.RESET_DM(24'h00_0180), .RESET_OUT(8'h81),
		.SFP_MASK(8'h01), .USB_MASK(8'h02)) i_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .periph_out, .periph_oe, .pin_in,
		.pad_out, .pad_oe, .pad_pu_en, .pad_pd_en, .pad_ibuf_en,
		.port_irq);

	pdm_pin_model #(.N(8)) i_pins (
		.pclk, .pad_out, .pad_oe, .pad_pu_en, .pad_pd_en, .ext_en,
		.ext_val, .pin_in);

	////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask

	// setup, then access held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (n > 20) begin
				mismatches++;
				conclude();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
			input string nm);
		apb(0, a, 8'h00);
		chk(nm, e, rd);
	endtask

	// mode the pad stage should act on after pin type and routing
	function automatic logic [2:0] eff(input int i);
		logic [2:0] c;
		c = code[i];
		if (i == 1 && c >= 2) c = 3'h6;
		if (i == 0 && rg[0] && c inside {2, 3, 7}) c = 3'h1;
		if (bid[i] && !periph_oe[i]) c = 3'h1;
		return c;
	endfunction

	task automatic setup();
		logic [7:0] m;
		apb(1, OFS_OUT, dv);
		for (int b = 0; b < 3; b++) begin
			for (int i = 0; i < 8; i++) m[i] = code[i][b];
			apb(1, 8'(OFS_DM0 + 4 * b), m);
		end
		apb(1, OFS_BYP, byp);
		apb(1, OFS_BIDIR, bid);
		apb(1, OFS_REGUL, rg);
		cyc(2);
	endtask

	task automatic chk_pads(input string nm);
		logic [7:0] o, e, u, p, b;
		logic [2:0] c;
		logic       d;
		for (int i = 0; i < 8; i++) begin
			c = eff(i);
			d = byp[i] ? periph_out[i] : dv[i];
			b[i] = c != 0;
			o[i] = d;
			e[i] = c == 6 || (d ? c inside {3, 5} : c inside {2, 4});
			u[i] = d && c inside {2, 7};
			p[i] = !d && c inside {3, 7};
		end
		chk({nm, " out"}, 32'(o), 32'(pad_out));
		chk({nm, " oe"}, 32'(e), 32'(pad_oe));
		chk({nm, " pu"}, 32'(u), 32'(pad_pu_en));
		chk({nm, " pd"}, 32'(p), 32'(pad_pd_en));
		chk({nm, " ibuf"}, 32'(b), 32'(pad_ibuf_en));
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		dv = 8'h81;
		byp = 8'h00;
		bid = 8'h00;
		rg = 8'h00;
		foreach (code[i]) code[i] = 3'h0;
		// pin 2 comes out of reset in strong drive
		code[2] = 3'h6;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rchk(OFS_OUT, 32'h0000_0081, "reset out");
		rchk(OFS_DM1, 32'h0000_0004, "reset drive");
		rchk(OFS_DM2, 32'h0000_0004, "reset drive hi");
		rchk(OFS_STATE, 32'h0000_0000, "reset state");
		chk_pads("reset");
		$display("test reset done");

		ext_en <= 8'h00;
		for (int r = 0; r < 2; r++)
			for (int d = 0; d < 2; d++) begin
				foreach (code[i]) code[i] = 3'(r ? 7 - i : i);
				dv = d ? 8'hFF : 8'h00;
				setup();
				chk_pads("modes");
			end
		$display("test modes done");

		rg = 8'h01;
		for (int c = 2; c < 8; c++) begin
			code[0] = 3'(c);
			code[1] = 3'(c);
			dv = c[0] ? 8'hFF : 8'h00;
			setup();
			chk_pads("special");
		end
		$display("test pin types done");

		rg = 8'h00;
		foreach (code[i]) code[i] = 3'h6;
		dv = 8'h0F;
		byp = 8'hF0;
		bid = 8'hCC;
		periph_out <= 8'h5A;
		periph_oe <= 8'hA0;
		setup();
		chk_pads("route");
		periph_oe <= 8'h0A;
		cyc(2);
		chk_pads("route oe");
		$display("test routing done");

		code = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h5, 3'h0, 3'h2};
		dv = 8'h90;
		byp = 8'h00;
		bid = 8'h00;
		ext_en <= 8'h7F;
		ext_val <= 8'h75;
		setup();
		cyc(4);
		rchk(OFS_STATE, 32'h0000_00B5, "state");
		apb(1, OFS_STATE, 8'hFF);
		rchk(OFS_OUT, 32'h0000_0090, "out kept");
		apb(1, 8'h4C, 8'h09);
		cyc(4);
		rchk(8'h4C, 32'h0000_0009, "pin form");
		rchk(OFS_DM2, 32'h0000_0038, "port form");
		rchk(OFS_OUT, 32'h0000_0098, "port out");
		$display("test pin state done");

		foreach (code[i]) code[i] = 3'h1;
		ext_en <= 8'hFF;
		ext_val <= 8'h00;
		setup();
		apb(1, OFS_IT0, 8'h0A);
		apb(1, OFS_IT1, 8'h0C);
		cyc(4);
		apb(1, OFS_STAT, 8'hFF);
		ext_val <= 8'h0F;
		cyc(5);
		chk("irq set", 32'h1, 32'(port_irq));
		rchk(OFS_STAT, 32'h0000_000A, "rise");
		apb(1, OFS_STAT, 8'h0F);
		cyc(8);
		rchk(OFS_STAT, 32'h0000_0000, "held level");
		chk("irq clear", 32'h0, 32'(port_irq));
		ext_val <= 8'h00;
		cyc(5);
		rchk(OFS_STAT, 32'h0000_000C, "fall");
		$display("test interrupts done");

		apb(0, 8'h30, 8'h00);
		chk("unmapped err", 32'h1, 32'(er));
		apb(0, 8'h60, 8'h00);
		chk("pin index err", 32'h1, 32'(er));
		chk("pin index data", 32'h0, rd);
		$display("test errors done");
		conclude();
	end
endmodule // testbench
`default_nettype wire
